// ### rtl/bsx_pkg.sv
/*
 * Constants, types and shared functions of the bit, shift and flag
 * execution unit.
 * Assumes a single core clock and a decoder that issues one operation
 * at a time.
 */
// Notes on behaviour
// - Rotate left through carry: bits move up, carry in at 0, bit 7 out; ZCNVH.
// - Rotate right through carry: bits move down, carry in at 7, bit 0 out; ZCNV.
// - Arithmetic shift right moves bits 1..7 down one place; ZCNV, one cycle.
// - Nibble exchange swaps high and low nibbles, no flag changes, one cycle.
// - Transfer flag to register bit writes T into the selected bit; no flags.
// - Status bit force one or zero changes only the selected flag bit.
// - Each flag, interrupt enable too, has its own one-cycle set and clear.
// - Break, no-op, sleep and watchdog restart take one cycle, no flags.
// - Listed access cycle counts hold for internal working memory.
// - Nonvolatile controller accesses take at least one extra cycle.
// - Nonvolatile accesses wait further while the controller is not ready.
package bsx_pkg;

    // ------------------------------------------------------------
    // Flag register layout
    // ------------------------------------------------------------
    localparam int FL_C = 0;
    localparam int FL_Z = 1;
    localparam int FL_N = 2;
    localparam int FL_V = 3;
    localparam int FL_S = 4;
    localparam int FL_H = 5;
    localparam int FL_T = 6;
    localparam int FL_I = 7;
    localparam logic [7:0] FLAGS_RESET = 8'h00;

    // ------------------------------------------------------------
    // Register port map
    // ------------------------------------------------------------
    localparam logic [5:0] ADDR_FLAGS   = 6'h00;
    localparam logic [5:0] ADDR_STATUS  = 6'h01;
    localparam logic [5:0] ADDR_IO_BASE = 6'h20;
    localparam int         IO_REGS      = 32;
    localparam logic [7:0] IO_RESET     = 8'h00;
    localparam logic [7:0] RD_UNMAPPED  = 8'h00;
    localparam int         ST_BUSY_BIT  = 0;

    // ------------------------------------------------------------
    // Access timing
    // ------------------------------------------------------------
    localparam logic [2:0] NVM_EXTRA_MIN = 3'h1;
    localparam logic [2:0] CNT_RESET     = 3'h0;

    // ------------------------------------------------------------
    // Operations issued by the decoder
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        OP_NONE                       = 5'h00,
        OP_ROTATE_LEFT_THROUGH_CARRY  = 5'h01,
        OP_ROTATE_RIGHT_THROUGH_CARRY = 5'h02,
        OP_ARITH_SHIFT_RIGHT          = 5'h03,
        OP_SWAP                       = 5'h04,
        OP_IO_SET                     = 5'h05,
        OP_IO_CLR                     = 5'h06,
        OP_REG_BIT_TO_TRANSFER_FLAG   = 5'h07,
        OP_TRANSFER_FLAG_TO_REG_BIT   = 5'h08,
        OP_FLAG_SET                   = 5'h09,
        OP_FLAG_CLR                   = 5'h0a,
        OP_GIE_SET                    = 5'h0b,
        OP_GIE_CLR                    = 5'h0c,
        OP_BREAK                      = 5'h0d,
        OP_NOP                        = 5'h0e,
        OP_SLEEP                      = 5'h0f,
        OP_WATCHDOG_RESTART           = 5'h10,
        OP_MEM                        = 5'h11
    } bsx_op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_MEM  = 2'b10
    } bsx_state_t;

    // Zero, negative, overflow and carry after a shift or rotate
    function automatic logic [7:0] bsx_shift_flags(input logic [7:0] f,
                                                   input logic [7:0] r,
                                                   input logic       c);
        logic [7:0] o;
        o       = f;
        o[FL_C] = c;
        o[FL_Z] = (r == 8'h00);
        o[FL_N] = r[7];
        o[FL_V] = r[7] ^ c;
        return o;
    endfunction

endpackage

// ### rtl/bsx_mem_if.sv
/*
 * Link between the execution unit and its data access timer.
 * Assumes both ends run on the core clock.
 */
`timescale 1ns/1ps
interface bsx_mem_if;
    logic       start;
    logic       nvm;
    logic [1:0] base;
    logic       nvm_ready;
    logic       finish;

    modport core  (output start, output nvm, output base, output nvm_ready, input finish);
    modport timer (input start, input nvm, input base, input nvm_ready, output finish);
endinterface

// ### rtl/bsx_mem_timer.sv
/*
 * Data access cycle timer.
 * Assumes the core raises start for one cycle and waits for finish.
 */
`timescale 1ns/1ps
module bsx_mem_timer (
    // Clock and reset
    input  wire logic  clock,
    input  wire logic  reset_n,
    // Core side
    bsx_mem_if.timer   mem
);
    import bsx_pkg::*;

    typedef struct packed {
        logic       run;
        logic       nvm;
        logic [2:0] cnt;
    } bsx_tmr_st_t;

    bsx_tmr_st_t st_ff;
    bsx_tmr_st_t nxt_st;
    logic [2:0]  total;

    always_comb begin
        nxt_st     = st_ff;
        mem.finish = 1'b0;
        total      = {1'b0, (mem.base == 2'h0) ? 2'h1 : mem.base}
                     + (mem.nvm ? NVM_EXTRA_MIN : 3'h0);
        if (mem.start) begin
            if (total == 3'h1) begin
                mem.finish = 1'b1;
            end else begin
                nxt_st.run = 1'b1;
                nxt_st.nvm = mem.nvm;
                nxt_st.cnt = total - 3'h1;
            end
        end else if (st_ff.run) begin
            if (st_ff.cnt > 3'h1) begin
                nxt_st.cnt = st_ff.cnt - 3'h1;
            end else if (!st_ff.nvm || mem.nvm_ready) begin
                mem.finish = 1'b1;
                nxt_st.run = 1'b0;
                nxt_st.cnt = CNT_RESET;
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '{run: 1'b0, nvm: 1'b0, cnt: CNT_RESET};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_int_one;
        @(posedge clock) disable iff (!reset_n)
        mem.start && !mem.nvm && mem.base <= 2'h1 |-> mem.finish;
    endproperty
    a_int_one: assert property (p_int_one) else $error("internal access not one cycle");

    property p_nvm_extra;
        @(posedge clock) disable iff (!reset_n)
        mem.start && mem.nvm && mem.base == 2'h1 |-> !mem.finish ##1 (st_ff.run);
    endproperty
    a_nvm_extra: assert property (p_nvm_extra) else $error("nvm access lacks extra cycle");

    property p_nvm_wait;
        @(posedge clock) disable iff (!reset_n)
        st_ff.run && st_ff.nvm && st_ff.cnt == 3'h1 && !mem.nvm_ready |-> !mem.finish;
    endproperty
    a_nvm_wait: assert property (p_nvm_wait) else $error("finished while nvm busy");
endmodule

// ### rtl/bsx_exec_unit.sv
/*
 * Bit, shift and flag execution unit with core control operations,
 * flag register, I/O bit registers and data access timing.
 * Assumes the decoder holds op_valid only while not busy is awaited,
 * and that register bus strobes are single cycle and never together.
 */
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module bsx_exec_unit (
    // Clock and reset
    input  wire  logic             clock,
    input  wire  logic             reset_n,
    // Operation request from the decoder
    input  wire  logic             op_valid,
    input  wire  bsx_pkg::bsx_op_t op_code,
    input  wire  logic [2:0]       op_sel,
    input  wire  logic [4:0]       op_addr,
    input  wire  logic [7:0]       op_data,
    input  wire  logic             op_mem_nvm,
    input  wire  logic [1:0]       op_mem_base,
    // Nonvolatile controller readiness
    input  wire  logic             nvm_ready,
    // Result to the register file
    output logic [7:0]             res_data,
    output logic                   res_we,
    output logic                   op_done,
    output logic                   busy,
    output logic [7:0]             flags,
    // Core control pulses
    output logic                   break_req,
    output logic                   sleep_req,
    output logic                   wdt_restart,
    // Register port
    input  wire  logic [5:0]       reg_addr,
    input  wire  logic [7:0]       reg_wdata,
    input  wire  logic             reg_wr,
    input  wire  logic             reg_rd,
    output logic [7:0]             reg_rdata
);
    import bsx_pkg::*;

    typedef struct packed {
        bsx_state_t             state;
        logic [7:0]             flags;
        logic [7:0]             res;
        logic                   res_we;
        logic                   done;
        logic                   busy;
        logic                   brk;
        logic                   slp;
        logic                   wdog;
        logic [7:0]             rdata;
        logic [IO_REGS-1:0][7:0] io;
    } bsx_exec_st_t;

    bsx_exec_st_t st_ff;
    bsx_exec_st_t nxt_st;
    bsx_mem_if    mem ();
    logic         accept;
    logic [4:0]   io_idx;

    // ------------------------------------------------------------
    // Data access timer
    // ------------------------------------------------------------
    bsx_mem_timer u_timer (
        .clock   (clock),
        .reset_n (reset_n),
        .mem     (mem.timer)
    );

    assign accept        = op_valid && !st_ff.busy;
    assign mem.start     = accept && (op_code == OP_MEM);
    assign mem.nvm       = op_mem_nvm;
    assign mem.base      = op_mem_base;
    assign mem.nvm_ready = nvm_ready;
    assign io_idx        = reg_addr[4:0];

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_st        = st_ff;
        nxt_st.res_we = 1'b0;
        nxt_st.done   = 1'b0;
        nxt_st.brk    = 1'b0;
        nxt_st.slp    = 1'b0;
        nxt_st.wdog   = 1'b0;
        nxt_st.rdata  = RD_UNMAPPED;

        // Register port; execution below overrides a same-cycle write
        if (reg_rd) begin
            if (reg_addr == ADDR_FLAGS) begin
                nxt_st.rdata = st_ff.flags;
            end else if (reg_addr == ADDR_STATUS) begin
                nxt_st.rdata[ST_BUSY_BIT] = st_ff.busy;
            end else if (reg_addr >= ADDR_IO_BASE) begin
                nxt_st.rdata = st_ff.io[io_idx];
            end
        end
        if (reg_wr) begin
            if (reg_addr == ADDR_FLAGS) begin
                nxt_st.flags = reg_wdata;
            end else if (reg_addr >= ADDR_IO_BASE) begin
                nxt_st.io[io_idx] = reg_wdata;
            end
        end

        case (st_ff.state)
            ST_IDLE: begin
                if (accept) begin
                    nxt_st.done = (op_code != OP_MEM);
                    case (op_code)
                        OP_ROTATE_LEFT_THROUGH_CARRY: begin
                            nxt_st.res    = {op_data[6:0], st_ff.flags[FL_C]};
                            nxt_st.res_we = 1'b1;
                            nxt_st.flags  = bsx_shift_flags(st_ff.flags, nxt_st.res,
                                                            op_data[7]);
                            nxt_st.flags[FL_H] = op_data[3];
                        end
                        OP_ROTATE_RIGHT_THROUGH_CARRY: begin
                            nxt_st.res    = {st_ff.flags[FL_C], op_data[7:1]};
                            nxt_st.res_we = 1'b1;
                            nxt_st.flags  = bsx_shift_flags(st_ff.flags, nxt_st.res,
                                                            op_data[0]);
                        end
                        OP_ARITH_SHIFT_RIGHT: begin
                            // Bit 7 stays so the sign survives
                            nxt_st.res    = {op_data[7], op_data[7:1]};
                            nxt_st.res_we = 1'b1;
                            nxt_st.flags  = bsx_shift_flags(st_ff.flags, nxt_st.res,
                                                            op_data[0]);
                        end
                        OP_SWAP: begin
                            nxt_st.res    = {op_data[3:0], op_data[7:4]};
                            nxt_st.res_we = 1'b1;
                        end
                        OP_IO_SET: begin
                            nxt_st.io[op_addr][op_sel] = 1'b1;
                        end
                        OP_IO_CLR: begin
                            nxt_st.io[op_addr][op_sel] = 1'b0;
                        end
                        OP_REG_BIT_TO_TRANSFER_FLAG: begin
                            nxt_st.flags[FL_T] = op_data[op_sel];
                        end
                        OP_TRANSFER_FLAG_TO_REG_BIT: begin
                            nxt_st.res         = op_data;
                            nxt_st.res[op_sel] = st_ff.flags[FL_T];
                            nxt_st.res_we      = 1'b1;
                        end
                        OP_FLAG_SET: begin
                            nxt_st.flags[op_sel] = 1'b1;
                        end
                        OP_FLAG_CLR: begin
                            nxt_st.flags[op_sel] = 1'b0;
                        end
                        OP_GIE_SET: begin
                            nxt_st.flags[FL_I] = 1'b1;
                        end
                        OP_GIE_CLR: begin
                            nxt_st.flags[FL_I] = 1'b0;
                        end
                        OP_BREAK: begin
                            nxt_st.brk = 1'b1;
                        end
                        OP_SLEEP: begin
                            nxt_st.slp = 1'b1;
                        end
                        OP_WATCHDOG_RESTART: begin
                            nxt_st.wdog = 1'b1;
                        end
                        OP_MEM: begin
                            // One-cycle internal access completes at once
                            if (mem.finish) begin
                                nxt_st.done = 1'b1;
                            end else begin
                                nxt_st.busy  = 1'b1;
                                nxt_st.state = ST_MEM;
                            end
                        end
                        default: begin
                            nxt_st.done = 1'b1;
                        end
                    endcase
                end
            end
            ST_MEM: begin
                // Stays stalled as long as the controller holds the access
                if (mem.finish) begin
                    nxt_st.done  = 1'b1;
                    nxt_st.busy  = 1'b0;
                    nxt_st.state = ST_IDLE;
                end
            end
            default: begin
                nxt_st.state = ST_IDLE;
                nxt_st.busy  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '{state: ST_IDLE, flags: FLAGS_RESET, res: 8'h00, res_we: 1'b0,
                       done: 1'b0, busy: 1'b0, brk: 1'b0, slp: 1'b0, wdog: 1'b0,
                       rdata: RD_UNMAPPED, io: {IO_REGS{IO_RESET}}};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign res_data    = st_ff.res;
    assign res_we      = st_ff.res_we;
    assign op_done     = st_ff.done;
    assign busy        = st_ff.busy;
    assign flags       = st_ff.flags;
    assign break_req   = st_ff.brk;
    assign sleep_req   = st_ff.slp;
    assign wdt_restart = st_ff.wdog;
    assign reg_rdata   = st_ff.rdata;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_rot_left;
        @(posedge clock) disable iff (!reset_n)
        accept && op_code == OP_ROTATE_LEFT_THROUGH_CARRY && !reg_wr |=> op_done && res_we
            && res_data == {$past(op_data[6:0]), $past(flags[FL_C])}
            && flags[FL_C] == $past(op_data[7]) && flags[FL_H] == $past(op_data[3]);
    endproperty
    a_rot_left: assert property (p_rot_left) else $error("rotate left result wrong");

    property p_rot_right;
        @(posedge clock) disable iff (!reset_n)
        accept && op_code == OP_ROTATE_RIGHT_THROUGH_CARRY && !reg_wr |=>
            res_data == {$past(flags[FL_C]), $past(op_data[7:1])}
            && flags[FL_C] == $past(op_data[0]) && flags[FL_Z] == (res_data == 8'h00);
    endproperty
    a_rot_right: assert property (p_rot_right) else $error("rotate right result wrong");

    property p_arith_shr;
        @(posedge clock) disable iff (!reset_n)
        accept && op_code == OP_ARITH_SHIFT_RIGHT && !reg_wr |=> res_data[7] == $past(op_data[7])
            && res_data[6:0] == $past(op_data[7:1]) && flags[FL_C] == $past(op_data[0]);
    endproperty
    a_arith_shr: assert property (p_arith_shr) else $error("arith shift right wrong");

    property p_swap;
        @(posedge clock) disable iff (!reset_n)
        accept && op_code == OP_SWAP && !reg_wr |=> $stable(flags)
            && res_data == {$past(op_data[3:0]), $past(op_data[7:4])};
    endproperty
    a_swap: assert property (p_swap) else $error("nibble exchange wrong");

    property p_io_set;
        @(posedge clock) disable iff (!reset_n)
        accept && op_code == OP_IO_SET && !reg_wr |=>
            st_ff.io[$past(op_addr)][$past(op_sel)] && $stable(flags) && !res_we;
    endproperty
    a_io_set: assert property (p_io_set) else $error("io bit not set");

    property p_io_clr;
        @(posedge clock) disable iff (!reset_n)
        accept && op_code == OP_IO_CLR && !reg_wr |=>
            !st_ff.io[$past(op_addr)][$past(op_sel)] && $stable(flags);
    endproperty
    a_io_clr: assert property (p_io_clr) else $error("io bit not cleared");

    property p_t_store;
        @(posedge clock) disable iff (!reset_n)
        accept && op_code == OP_REG_BIT_TO_TRANSFER_FLAG && !reg_wr
            |=> flags[FL_T] == $past(op_data[op_sel])
            && flags[5:0] == $past(flags[5:0]) && flags[FL_I] == $past(flags[FL_I]);
    endproperty
    a_t_store: assert property (p_t_store) else $error("transfer flag store wrong");

    property p_t_load;
        @(posedge clock) disable iff (!reset_n)
        accept && op_code == OP_TRANSFER_FLAG_TO_REG_BIT && !reg_wr |=> res_we && $stable(flags)
            && res_data[$past(op_sel)] == $past(flags[FL_T]);
    endproperty
    a_t_load: assert property (p_t_load) else $error("transfer flag load wrong");

    property p_flag_set;
        @(posedge clock) disable iff (!reset_n)
        accept && op_code == OP_FLAG_SET && !reg_wr |=>
            flags == ($past(flags) | (8'h01 << $past(op_sel)));
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag set touched others");

    property p_flag_clr;
        @(posedge clock) disable iff (!reset_n)
        accept && op_code == OP_FLAG_CLR && !reg_wr |=>
            flags == ($past(flags) & ~(8'h01 << $past(op_sel)));
    endproperty
    a_flag_clr: assert property (p_flag_clr) else $error("flag clear touched others");

    // A control op taken right behind may raise its own pulse again
    property p_ctrl;
        @(posedge clock) disable iff (!reset_n)
        accept && !reg_wr
            && (op_code == OP_SLEEP || op_code == OP_WATCHDOG_RESTART || op_code == OP_NOP)
            |=> op_done && $stable(flags) ##1 ((!sleep_req && !wdt_restart) || $past(accept));
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("control op not one cycle");
endmodule

// ### sim/bsx_nvm_model.sv
/*
 * Nonvolatile controller readiness model for the execution unit.
 * Assumes the bench pulses kick beside the access that is to stall.
 */
`timescale 1ns/1ps
module bsx_nvm_model (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       reset_n,
    // Stall control
    input  wire logic       kick,
    input  wire logic [3:0] stall_len,
    // Toward the unit
    output logic            nvm_ready
);
    logic [3:0] wait_ff;
    logic [3:0] nxt_wait;

    // Busy controller holds the core for stall_len cycles
    assign nxt_wait  = kick ? stall_len : (wait_ff != 4'h0) ? wait_ff - 4'h1 : 4'h0;
    assign nvm_ready = (wait_ff == 4'h0);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wait_ff <= 4'h0;
        end else begin
            wait_ff <= nxt_wait;
        end
    end
endmodule

// ### sim/test_bit_shift_flag_exec_unit.sv
/*
 * Self-checking bench of the execution unit: row table, then flag, I/O, timing and reset cases.
 * Assumes the package constants and a readiness model at the far side.
 */
`timescale 1ns/1ps
module test_bit_shift_flag_exec_unit;
    import bsx_pkg::*;
    typedef struct packed {
        bsx_op_t op; logic [2:0] sel; logic [7:0] data; logic [7:0] fin;
        logic we; logic [7:0] rexp; logic [7:0] fexp; logic [2:0] pexp;
    } bsx_row_t;
    logic clock, reset_n, op_valid, op_mem_nvm, nvm_ready, res_we, op_done, busy;
    logic break_req, sleep_req, wdt_restart, reg_wr, reg_rd, kick;
    bsx_op_t op_code;
    logic [2:0] op_sel;
    logic [4:0] op_addr;
    logic [1:0] op_mem_base;
    logic [3:0] stall_len;
    logic [5:0] reg_addr;
    logic [7:0] op_data, res_data, flags, reg_wdata, reg_rdata, rd;
    int failures, n_checks, cnt;
    bsx_row_t rows [16];

    bsx_exec_unit DUT (.clock(clock), .reset_n(reset_n), .op_valid(op_valid),
        .op_code(op_code), .op_sel(op_sel), .op_addr(op_addr), .op_data(op_data),
        .op_mem_nvm(op_mem_nvm), .op_mem_base(op_mem_base), .nvm_ready(nvm_ready),
        .res_data(res_data), .res_we(res_we), .op_done(op_done), .busy(busy),
        .flags(flags), .break_req(break_req), .sleep_req(sleep_req),
        .wdt_restart(wdt_restart), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    bsx_nvm_model u_nvm (.clock(clock), .reset_n(reset_n), .kick(kick),
        .stall_len(stall_len), .nvm_ready(nvm_ready));

    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic reg_write(input logic [5:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [5:0] a);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        rd = reg_rdata;
    endtask
    task automatic issue(input bsx_op_t op, input logic [2:0] s, input logic [7:0] d,
                         input logic [4:0] a);
        @(posedge clock);
        op_valid <= 1'b1;
        op_code <= op;
        op_sel <= s;
        op_data <= d;
        op_addr <= a;
        @(posedge clock);
        op_valid <= 1'b0;
        #1;
    endtask
    // Bounded wait; cnt is the cycle of op_done counted from the call, which is cycle 1
    task automatic wait_done();
        cnt = 1;
        while (op_done !== 1'b1) begin
            if (cnt == 20) begin
                failures++;
                summarize();
            end
            @(posedge clock);
            #1;
            cnt++;
        end
    endtask

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    initial begin
        {reset_n, op_valid, op_mem_nvm, reg_wr, reg_rd, kick} = 6'h00;
        {op_sel, op_addr, op_mem_base, stall_len, reg_addr} = 20'h00000;
        {op_data, reg_wdata} = 16'h0000;
        op_code = OP_NONE;
        rows = '{'{OP_ROTATE_LEFT_THROUGH_CARRY, 3'h0, 8'h88, 8'h01, 1'b1, 8'h11, 8'h29, 3'h0},
                 '{OP_ROTATE_LEFT_THROUGH_CARRY, 3'h0, 8'h80, 8'h00, 1'b1, 8'h00, 8'h0b, 3'h0},
                 '{OP_ROTATE_RIGHT_THROUGH_CARRY, 3'h0, 8'h01, 8'h11, 1'b1, 8'h80, 8'h15, 3'h0},
                 '{OP_ARITH_SHIFT_RIGHT, 3'h0, 8'h81, 8'h20, 1'b1, 8'hc0, 8'h25, 3'h0},
                 '{OP_ARITH_SHIFT_RIGHT, 3'h0, 8'h01, 8'h00, 1'b1, 8'h00, 8'h0b, 3'h0},
                 '{OP_SWAP, 3'h0, 8'ha5, 8'hff, 1'b1, 8'h5a, 8'hff, 3'h0},
                 '{OP_REG_BIT_TO_TRANSFER_FLAG, 3'h6, 8'h40, 8'h00, 1'b0, 8'h00, 8'h40, 3'h0},
                 '{OP_REG_BIT_TO_TRANSFER_FLAG, 3'h6, 8'hbf, 8'hff, 1'b0, 8'h00, 8'hbf, 3'h0},
                 '{OP_TRANSFER_FLAG_TO_REG_BIT, 3'h3, 8'h00, 8'h40, 1'b1, 8'h08, 8'h40, 3'h0},
                 '{OP_TRANSFER_FLAG_TO_REG_BIT, 3'h0, 8'hff, 8'hbf, 1'b1, 8'hfe, 8'hbf, 3'h0},
                 '{OP_GIE_SET, 3'h0, 8'h00, 8'h00, 1'b0, 8'h00, 8'h80, 3'h0},
                 '{OP_GIE_CLR, 3'h0, 8'h00, 8'hff, 1'b0, 8'h00, 8'h7f, 3'h0},
                 '{OP_BREAK, 3'h0, 8'h00, 8'ha5, 1'b0, 8'h00, 8'ha5, 3'h4},
                 '{OP_SLEEP, 3'h0, 8'h00, 8'ha5, 1'b0, 8'h00, 8'ha5, 3'h2},
                 '{OP_WATCHDOG_RESTART, 3'h0, 8'h00, 8'ha5, 1'b0, 8'h00, 8'ha5, 3'h1},
                 '{OP_NOP, 3'h0, 8'h00, 8'h5a, 1'b0, 8'h00, 8'h5a, 3'h0}};
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        #1;
        chk(flags, FLAGS_RESET);
        foreach (rows[i]) begin
            reg_write(ADDR_FLAGS, rows[i].fin);
            issue(rows[i].op, rows[i].sel, rows[i].data, 5'h00);
            chk({7'h00, op_done}, 8'h01);
            chk({7'h00, res_we}, {7'h00, rows[i].we});
            if (rows[i].we) chk(res_data, rows[i].rexp);
            chk(flags, rows[i].fexp);
            chk({5'h00, break_req, sleep_req, wdt_restart}, {5'h00, rows[i].pexp});
        end
        $display("row table done");
        for (int b = 0; b < 8; b++) begin
            reg_write(ADDR_FLAGS, 8'h00);
            issue(OP_FLAG_SET, 3'(b), 8'h00, 5'h00);
            chk(flags, 8'h01 << b);
            reg_write(ADDR_FLAGS, 8'hff);
            issue(OP_FLAG_CLR, 3'(b), 8'h00, 5'h00);
            chk(flags, ~(8'h01 << b));
        end
        reg_write(ADDR_FLAGS, 8'h00);
        @(posedge clock);
        op_valid <= 1'b1;
        op_code <= OP_FLAG_SET;
        op_sel <= 3'h0;
        @(posedge clock);
        op_code <= OP_GIE_SET;
        @(posedge clock);
        op_valid <= 1'b0;
        #1;
        chk(flags, 8'h81);
        $display("flag tests done");
        reg_write(ADDR_FLAGS, 8'h3c);
        issue(OP_IO_SET, 3'h3, 8'h00, 5'h05);
        chk(flags, 8'h3c);
        reg_read(ADDR_IO_BASE + 6'h05);
        chk(rd, 8'h08);
        reg_write(ADDR_IO_BASE + 6'h05, 8'hff);
        issue(OP_IO_CLR, 3'h7, 8'h00, 5'h05);
        chk(flags, 8'h3c);
        reg_read(ADDR_IO_BASE + 6'h05);
        chk(rd, 8'h7f);
        reg_read(6'h10);
        chk(rd, RD_UNMAPPED);
        $display("io tests done");
        for (int i = 0; i < 4; i++) begin
            @(posedge clock);
            op_valid <= 1'b1;
            op_code <= OP_MEM;
            op_mem_nvm <= (i > 1);
            op_mem_base <= 2'(i == 0 ? 2 : i == 1 ? 0 : i == 2 ? 1 : 3);
            @(posedge clock);
            op_valid <= 1'b0;
            #1;
            wait_done();
            chk(8'(cnt), 8'(i == 0 ? 2 : i == 1 ? 1 : i == 2 ? 2 : 4));
        end
        reg_write(ADDR_FLAGS, 8'h00);
        @(posedge clock);
        op_valid <= 1'b1;
        op_mem_base <= 2'h1;
        kick <= 1'b1;
        stall_len <= 4'h4;
        @(posedge clock);
        op_valid <= 1'b0;
        kick <= 1'b0;
        #1;
        chk({7'h00, busy}, 8'h01);
        issue(OP_GIE_SET, 3'h0, 8'h00, 5'h00);
        reg_read(ADDR_STATUS);
        chk(rd, 8'h01);
        wait_done();
        // Done lands stall_len + 1 edges after the take; cnt is 1 four edges after it
        chk(8'(cnt + 3), 8'(stall_len + 1));
        chk(flags, 8'h00);
        $display("access timing done");
        reg_write(ADDR_FLAGS, 8'hff);
        @(posedge clock);
        reset_n <= 1'b0;
        @(posedge clock);
        #1;
        chk(flags, FLAGS_RESET);
        $display("reset test done");
        summarize();
    end
endmodule
